// ### pkg/nvspi_pkg.sv
/*
  Shared constants and types for the serial nonvolatile memory SPI slave:
  array geometry, opcodes, status register layout, protection ranges,
  command phase encoding and the commit record handed to the core side.
  Assumes a SystemVerilog-2012 compiler; no other dependency.
*/
package nvspi_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OPC_WRSR = 8'h01;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_WREN = 8'h06;

  // ****************************************
  // Status register layout
  // ****************************************
  localparam int ST_PIN_EN_BIT = 7;
  localparam int ST_BP_HI_BIT = 3;
  localparam int ST_BP_LO_BIT = 2;
  localparam int ST_WEL_BIT = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'h8c;

  // Block protection codes and the lowest guarded address of the quarter and half codes
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [10:0] QUARTER_BASE = 11'h600;
  localparam logic [10:0] HALF_BASE = 11'h400;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [7:0] {
    PH_OPCODE = 8'h01,
    PH_ADDR_HI = 8'h02,
    PH_ADDR_LO = 8'h04,
    PH_WR_DATA = 8'h08,
    PH_RD_DATA = 8'h10,
    PH_STAT_RD = 8'h20,
    PH_STAT_WR = 8'h40,
    PH_IGNORE = 8'h80
  } phase_t;

  typedef struct packed {
    logic isStatus;
    logic [10:0] addr;
    logic [7:0] data;
  } commit_t;

endpackage

// ### hdl/serial_nv_memory_spi_slave.sv
/*
  SPI slave front end of a 2K x 8 nonvolatile memory, array included.
  The command logic runs on the serial clock itself (rising edge samples,
  falling edge launches); a core_clk side reports committed writes and the
  status register through a toggle handshake and two-flop crossings.
  Assumes the master keeps csN, si, wpN and holdN steady around sck edges,
  so these are treated as belonging to the serial clock domain.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Chip select high: standby, inputs ignored, serial output released.
// - Each opcode follows a fresh chip select falling edge.
// - Serial clock acts on internal logic only while selected.
// - Serial input sampled on rising clock edges only.
// - Output data changes on falling clock edges.
// - Output driven only while returning read data, never during hold.
// - Fully static; clock may run slowly or stop anywhere.
// - Write-protect low with pin enable set blocks status writes.
// - Hold low freezes the operation and ignores clock and select.
// - Each data byte committed on its eighth bit, no busy time.
// - SPI modes 0 and 3 supported, nothing else.
// - Array of 2048 locations, eight bits each.
// - Block protection guards upper quarter, upper half or all.
// - Write disable blocks memory and status writes until re-enabled.
// - Clock level at selection picks mode 0 or mode 3.
// - Unknown opcode: ignore everything until next selection, output off.
// - Two address bytes, MSB first, only the low 11 bits used.
// - Opcodes, addresses and data shift most significant bit first.
module serial_nv_memory_spi_slave (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic wpN,
  input wire logic holdN,
  output logic so,
  output logic soOe,
  output logic commitValid,
  output nvspi_pkg::commit_t commitInfo,
  output logic [7:0] statusMirror,
  output logic spiMode3
);

  // ****************************************
  // Helpers
  // ****************************************

  // Phase that follows a complete opcode byte
  function automatic nvspi_pkg::phase_t decodeOpcode(input logic [7:0] op);
    nvspi_pkg::phase_t ph;
    case (op)
      nvspi_pkg::OPC_READ: ph = nvspi_pkg::PH_ADDR_HI;
      nvspi_pkg::OPC_WRITE: ph = nvspi_pkg::PH_ADDR_HI;
      nvspi_pkg::OPC_RDSR: ph = nvspi_pkg::PH_STAT_RD;
      nvspi_pkg::OPC_WRSR: ph = nvspi_pkg::PH_STAT_WR;
      default: ph = nvspi_pkg::PH_IGNORE;
    endcase
    return ph;
  endfunction

  // Address falls inside the guarded block
  function automatic logic isGuarded(input logic [10:0] a,
                                     input logic [1:0] bp);
    logic g;
    case (bp)
      nvspi_pkg::BP_QUARTER: g = (a >= nvspi_pkg::QUARTER_BASE);
      nvspi_pkg::BP_HALF: g = (a >= nvspi_pkg::HALF_BASE);
      nvspi_pkg::BP_ALL: g = 1'b1;
      default: g = 1'b0;
    endcase
    return g;
  endfunction

  // ****************************************
  // Core-side reset synchroniser
  // ****************************************
  logic rstMeta_r;
  logic rstSyncN_r;

  // Release of resetn is retimed; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_r <= 1'b0;
      rstSyncN_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSyncN_r <= rstMeta_r;
    end
  end

  // ****************************************
  // Serial clock domain: receive side
  // ****************************************
  logic [7:0] mem [nvspi_pkg::MEM_DEPTH];
  nvspi_pkg::phase_t phase_r, phaseNxt;
  logic [2:0] bitCnt_r, bitCntNxt;
  logic [7:0] shift_r, shiftNxt;
  logic [10:0] addr_r, addrNxt;
  logic opRead_r, opReadNxt;
  logic sawRise_r, sawRiseNxt;
  logic [7:0] status_r, statusNxt;
  logic commitTgl_r, commitTglNxt;
  nvspi_pkg::commit_t commitRec_r, commitRecNxt;
  logic frameRst;
  logic [7:0] rxByte;
  logic byteDone;
  logic memWe;
  logic wel;
  logic pinLock;

  // Deselect clears the frame, but not while hold masks chip select
  assign frameRst = csN & holdN;
  assign rxByte = {shift_r[6:0], si};
  assign byteDone = (bitCnt_r == nvspi_pkg::LAST_BIT);
  assign wel = status_r[nvspi_pkg::ST_WEL_BIT];
  assign pinLock = ~wpN & status_r[nvspi_pkg::ST_PIN_EN_BIT];

  // Next state of the command decoder at each rising edge
  always_comb
  begin
    phaseNxt = phase_r;
    bitCntNxt = bitCnt_r;
    shiftNxt = shift_r;
    addrNxt = addr_r;
    opReadNxt = opRead_r;
    sawRiseNxt = sawRise_r;
    statusNxt = status_r;
    commitTglNxt = commitTgl_r;
    commitRecNxt = commitRec_r;
    memWe = 1'b0;
    if (holdN && !csN)
    begin
      bitCntNxt = bitCnt_r + 3'h1;
      shiftNxt = rxByte;
      sawRiseNxt = 1'b1;
      case (phase_r)
        nvspi_pkg::PH_OPCODE:
        begin
          if (byteDone)
          begin
            phaseNxt = decodeOpcode(rxByte);
            opReadNxt = (rxByte == nvspi_pkg::OPC_READ);
            if (rxByte == nvspi_pkg::OPC_WREN)
              statusNxt[nvspi_pkg::ST_WEL_BIT] = 1'b1;
            if (rxByte == nvspi_pkg::OPC_WRDI)
              statusNxt[nvspi_pkg::ST_WEL_BIT] = 1'b0;
            if (rxByte == nvspi_pkg::OPC_WREN
                || rxByte == nvspi_pkg::OPC_WRDI)
              phaseNxt = nvspi_pkg::PH_IGNORE;
          end
        end
        nvspi_pkg::PH_ADDR_HI:
        begin
          if (byteDone)
          begin
            addrNxt[10:8] = rxByte[2:0];
            phaseNxt = nvspi_pkg::PH_ADDR_LO;
          end
        end
        nvspi_pkg::PH_ADDR_LO:
        begin
          if (byteDone)
          begin
            addrNxt[7:0] = rxByte;
            phaseNxt = opRead_r ? nvspi_pkg::PH_RD_DATA
                                : nvspi_pkg::PH_WR_DATA;
          end
        end
        nvspi_pkg::PH_WR_DATA:
        begin
          if (byteDone)
          begin
            // Commit on the eighth bit, so no busy period exists
            memWe = wel
              & ~isGuarded(addr_r, status_r[3:2]);
            addrNxt = addr_r + 11'h1;
          end
        end
        nvspi_pkg::PH_RD_DATA:
        begin
          if (byteDone)
            addrNxt = addr_r + 11'h1; // Wraps at the top of the array
        end
        nvspi_pkg::PH_STAT_WR:
        begin
          if (byteDone)
          begin
            if (wel && !pinLock)
              statusNxt = (status_r & ~nvspi_pkg::STATUS_WR_MASK)
                        | (rxByte & nvspi_pkg::STATUS_WR_MASK);
            phaseNxt = nvspi_pkg::PH_IGNORE;
          end
        end
        nvspi_pkg::PH_STAT_RD: phaseNxt = phase_r;
        nvspi_pkg::PH_IGNORE: phaseNxt = phase_r;
        default: phaseNxt = nvspi_pkg::PH_IGNORE;
      endcase
    end
    // Every array or status change is reported to the core side
    if (memWe)
    begin
      commitTglNxt = ~commitTgl_r;
      commitRecNxt = '{isStatus: 1'b0, addr: addr_r, data: rxByte};
    end
    else if (statusNxt != status_r)
    begin
      commitTglNxt = ~commitTgl_r;
      commitRecNxt = '{isStatus: 1'b1, addr: 11'h000, data: statusNxt};
    end
  end

  // Frame state, cleared whenever the device is deselected with hold released
  always_ff @(posedge sck or posedge frameRst)
  begin
    if (frameRst)
    begin
      phase_r <= nvspi_pkg::PH_OPCODE;
      bitCnt_r <= nvspi_pkg::FIRST_BIT;
      shift_r <= 8'h00;
      addr_r <= 11'h000;
      opRead_r <= 1'b0;
      sawRise_r <= 1'b0;
    end
    else
    begin
      phase_r <= phaseNxt;
      bitCnt_r <= bitCntNxt;
      shift_r <= shiftNxt;
      addr_r <= addrNxt;
      opRead_r <= opReadNxt;
      sawRise_r <= sawRiseNxt;
    end
  end

  // Persistent state survives deselect; only power-on reset clears it
  always_ff @(posedge sck or negedge rstSyncN_r)
  begin
    if (!rstSyncN_r)
    begin
      status_r <= nvspi_pkg::STATUS_RST;
      commitTgl_r <= 1'b0;
      commitRec_r <= '0;
    end
    else
    begin
      status_r <= statusNxt;
      commitTgl_r <= commitTglNxt;
      commitRec_r <= commitRecNxt;
    end
  end

  // Array write port; no reset, contents are nonvolatile
  always_ff @(posedge sck)
  begin
    if (memWe)
      mem[addr_r] <= rxByte;
  end

  // ****************************************
  // Serial clock domain: transmit side
  // ****************************************
  logic [7:0] tx_r, txNxt;
  logic driving_r, drivingNxt;
  logic mode3_r, mode3Nxt;
  logic sawFall_r, sawFallNxt;
  logic loadByte;

  // A new byte is fetched at the falling edge before its first bit
  assign loadByte = (phase_r == nvspi_pkg::PH_RD_DATA
                     || phase_r == nvspi_pkg::PH_STAT_RD)
                    && (bitCnt_r == nvspi_pkg::FIRST_BIT);

  // Next output shift state at each falling edge
  always_comb
  begin
    txNxt = tx_r;
    drivingNxt = driving_r;
    mode3Nxt = mode3_r;
    sawFallNxt = sawFall_r;
    if (holdN && !csN)
    begin
      // First fall of a frame with no rise before it: clock idled high
      if (!sawFall_r)
        mode3Nxt = ~sawRise_r;
      sawFallNxt = 1'b1;
      if (loadByte)
      begin
        txNxt = (phase_r == nvspi_pkg::PH_RD_DATA) ? mem[addr_r]
                                                   : status_r;
        drivingNxt = 1'b1;
      end
      else
        txNxt = {tx_r[6:0], 1'b0};
    end
  end

  // Launch register; falling edge keeps half a period of setup
  always_ff @(negedge sck or posedge frameRst)
  begin
    if (frameRst)
    begin
      tx_r <= 8'h00;
      driving_r <= 1'b0;
      sawFall_r <= 1'b0;
    end
    else
    begin
      tx_r <= txNxt;
      driving_r <= drivingNxt;
      sawFall_r <= sawFallNxt;
    end
  end

  // Mode survives deselect so the core side can report the last frame
  always_ff @(negedge sck or negedge rstSyncN_r)
  begin
    if (!rstSyncN_r)
      mode3_r <= 1'b0;
    else
      mode3_r <= mode3Nxt;
  end

  assign so = tx_r[7];
  // Released at once on deselect or hold, without waiting for a clock
  assign soOe = driving_r & ~csN & holdN;

  // ****************************************
  // Core clock domain: reporting
  // ****************************************
  logic tglMeta_r, tglSync_r, tglSeen_r;
  logic tglSeenNxt;
  logic modeMeta_r, modeSync_r;
  logic commitValid_r, commitValidNxt;
  nvspi_pkg::commit_t commitOut_r, commitOutNxt;
  logic [7:0] mirror_r, mirrorNxt;
  logic tglEdge;

  // The record is stable for a whole byte time after its toggle moves
  assign tglEdge = tglSync_r ^ tglSeen_r;

  // Capture and forward a commit once its toggle has crossed
  always_comb
  begin
    tglSeenNxt = tglSync_r;
    commitValidNxt = tglEdge;
    commitOutNxt = commitOut_r;
    mirrorNxt = mirror_r;
    if (tglEdge)
    begin
      commitOutNxt = commitRec_r;
      if (commitRec_r.isStatus)
        mirrorNxt = commitRec_r.data;
    end
  end

  // Synchronisers and output registers; ce low freezes them all
  always_ff @(posedge core_clk or negedge rstSyncN_r)
  begin
    if (!rstSyncN_r)
    begin
      tglMeta_r <= 1'b0;
      tglSync_r <= 1'b0;
      tglSeen_r <= 1'b0;
      modeMeta_r <= 1'b0;
      modeSync_r <= 1'b0;
      commitValid_r <= 1'b0;
      commitOut_r <= '0;
      mirror_r <= nvspi_pkg::STATUS_RST;
    end
    else if (ce)
    begin
      tglMeta_r <= commitTgl_r;
      tglSync_r <= tglMeta_r;
      tglSeen_r <= tglSeenNxt;
      modeMeta_r <= mode3_r;
      modeSync_r <= modeMeta_r;
      commitValid_r <= commitValidNxt;
      commitOut_r <= commitOutNxt;
      mirror_r <= mirrorNxt;
    end
  end

  assign commitValid = commitValid_r;
  assign commitInfo = commitOut_r;
  assign statusMirror = mirror_r;
  assign spiMode3 = modeSync_r;

endmodule

// ### sim/nvspi_checker.sv
/*
  Assertions on the SPI memory slave: output enable and core-side report.
  Bound to the top module; sees only its ports, core clock domain.
*/
`timescale 1ns/1ps
module nvspi_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic csN,
  input wire logic holdN,
  input wire logic soOe,
  input wire logic commitValid,
  input wire nvspi_pkg::commit_t commitInfo,
  input wire logic [7:0] statusMirror
);
  // ****************************************
  // Relations
  // ****************************************
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [1:0] bp;
  logic arr;
  // Guard fields, so each property stays short
  assign bp = statusMirror[3:2];
  assign arr = commitValid && !commitInfo.isStatus;
  sequence oneShot;
    commitValid ##1 !commitValid;
  endsequence
  oe_deselect_a: assert property (csN |-> !soOe)
    else $error("output enabled while deselected");
  oe_hold_a: assert property (!holdN |-> !soOe)
    else $error("output enabled during suspend");
  commit_pulse_a: assert property ($rose(commitValid) |-> oneShot)
    else $error("commit strobe longer than one cycle");
  info_hold_a: assert property ($changed(commitInfo) |-> commitValid)
    else $error("commit record moved without strobe");
  mirror_cause_a: assert property (
    $changed(statusMirror) |-> commitValid && commitInfo.isStatus)
    else $error("status mirror moved without status commit");
  status_rsvd_a: assert property ((statusMirror & 8'h71) == 8'h00)
    else $error("status bit outside writable set");
  write_enable_a: assert property (arr |-> statusMirror[1])
    else $error("array write with write latch clear");
  block_guard_a: assert property (
    arr |-> bp == 2'h0
    || (bp == 2'h1 && commitInfo.addr < nvspi_pkg::QUARTER_BASE)
    || (bp == 2'h2 && commitInfo.addr < nvspi_pkg::HALF_BASE))
    else $error("array write inside guarded range");
endmodule

bind serial_nv_memory_spi_slave nvspi_checker chk (.core_clk, .resetn,
  .csN, .holdN, .soOe, .commitValid, .commitInfo, .statusMirror);

// ### sim/spi_host_model.sv
/*
  Behavioural SPI master facing the memory slave, sck period 32 ns.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module spi_host_model (
  output logic sck,
  output logic csN,
  output logic si,
  output logic holdN,
  output logic wpN,
  input wire logic so,
  input wire logic soOe
);
  // ****************************************
  // Frame tasks
  // ****************************************
  bit m3;
  // Idle: deselected, no suspend, protect pin released
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    holdN = 1'b1;
    wpN = 1'b1;
  end
  // Idle level of sck picks the mode before select falls
  task automatic start(input bit mode3);
    m3 = mode3;
    sck = mode3;
    #16 csN = 1'b0;
    #16;
  endtask
  // MSB first; an undriven output reads as z, never as data
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      #16 sck = 1'b1;
      rx[i] = soOe ? so : 1'bz;
      #16;
    end
  endtask
  // Released data line shows the inverse, not the last bit
  task automatic stop();
    if (!m3)
    begin
      sck = 1'b0;
      #16;
    end
    csN = 1'b1;
    si = ~si;
    #32;
  endtask
  // Suspend with sck low; edges and select wiggle meanwhile
  task automatic suspend(output bit sawOe);
    sawOe = 1'b0;
    sck = 1'b0;
    #16 holdN = 1'b0;
    repeat (2)
    begin
      sck = 1'b1;
      csN = 1'b1;
      si = ~si;
      #8 sawOe |= soOe;
      #8 sck = 1'b0;
      csN = 1'b0;
      #16;
    end
    holdN = 1'b1;
    #16;
  endtask
  // Protect pin level, held across the following frames
  task automatic setWp(input bit level);
    wpN = level;
  endtask
endmodule

// ### sim/tb_serial_nv_memory_spi_slave.sv
/*
  Self-checking bench for the SPI memory slave.
  Assumes the checker is bound and the host model drives the pins.
*/
`timescale 1ns/1ps
module tb_serial_nv_memory_spi_slave;
  // ****************************************
  // Harness
  // ****************************************
  logic core_clk, resetn, ce, so, soOe, commitValid, spiMode3;
  logic sck, csN, si, wpN, holdN;
  logic [7:0] statusMirror, rx;
  nvspi_pkg::commit_t commitInfo, last;
  int n_fail, num_checks, commits;
  bit saw;
  serial_nv_memory_spi_slave dut (.core_clk, .resetn, .ce, .sck,
    .csN, .si, .wpN, .holdN, .so, .soOe, .commitValid, .commitInfo,
    .statusMirror, .spiMode3);
  spi_host_model h (.sck, .csN, .si, .holdN, .wpN, .so, .soOe);
  // Core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Counts commits away from the edge that updates them
  always @(negedge core_clk)
    if (commitValid === 1'b1)
    begin
      commits++;
      last = commitInfo;
    end
  task automatic check(input string what, input logic [19:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Whole frame of nb bytes from the top of w; rx keeps the last byte
  task automatic run(input bit m3, input logic [31:0] w, input int nb);
    h.start(m3);
    for (int i = 0; i < nb; i++)
      h.xfer(w[31-8*i -: 8], rx);
    h.stop();
    repeat (8) @(posedge core_clk);
  endtask
  // Upper five address bits set, so they must be dropped
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    run(1'b1, {nvspi_pkg::OPC_WRITE, 5'h1f, a, d}, 4);
  endtask
  task automatic wrsr(input logic [7:0] d);
    run(1'b0, {nvspi_pkg::OPC_WRSR, d, 16'h0000}, 2);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write_read();
    run(1'b0, {nvspi_pkg::OPC_WREN, 24'h000000}, 1);
    wr(11'h7ff, 8'ha5);
    check("commit", last, {1'b0, 11'h7ff, 8'ha5});
    check("mode3", spiMode3, 1'b1);
    run(1'b0, {nvspi_pkg::OPC_READ, 16'h07ff, 8'h00}, 4);
    check("read", rx, 8'ha5);
    check("mode0", spiMode3, 1'b0);
  endtask
  task automatic t_protect();
    int c;
    for (int b = 0; b < 4; b++)
    begin
      wrsr({4'h0, b[1:0], 2'h0});
      check("bp", statusMirror, {4'h0, b[1:0], 2'h2});
      c = commits;
      wr(11'h400, 8'h11);
      wr(11'h000, 8'h22);
      check("guard", commits - c, (b < 2) + (b < 3));
    end
    wrsr(8'h00);
  endtask
  task automatic t_wp();
    wrsr(8'h80);
    h.setWp(1'b0);
    wrsr(8'h00);
    check("wp", statusMirror, 8'h82);
    // Status read in mode 3, so a read runs with the clock idling high
    run(1'b1, {nvspi_pkg::OPC_RDSR, 24'h000000}, 2);
    check("rdsr", rx, 8'h82);
    h.setWp(1'b1);
    wrsr(8'h00);
    check("wp off", statusMirror, 8'h02);
  endtask
  task automatic t_abort_hold();
    int c;
    c = commits;
    run(1'b0, {nvspi_pkg::OPC_WRITE, 16'h0020, 8'h00}, 3);
    run(1'b0, {8'hff, nvspi_pkg::OPC_READ, 16'h07ff}, 4);
    check("bad op", rx, 8'hzz);
    check("no commit", commits - c, 0);
    h.start(1'b0);
    h.xfer(nvspi_pkg::OPC_READ, rx);
    h.xfer(8'h07, rx);
    h.xfer(8'hff, rx);
    h.suspend(saw);
    h.xfer(8'h00, rx);
    h.stop();
    check("held oe", saw, 1'b0);
    check("held read", rx, 8'ha5);
  endtask
  task automatic t_wrdi();
    int c;
    c = commits;
    // Core enable low: the report side must hold still until released
    @(negedge core_clk) ce = 1'b0;
    run(1'b0, {nvspi_pkg::OPC_WRDI, 24'h000000}, 1);
    check("frozen", commits - c, 0);
    check("frozen mirror", statusMirror, 8'h02);
    @(negedge core_clk) ce = 1'b1;
    repeat (8) @(posedge core_clk);
    check("wrdi", statusMirror, 8'h00);
    c = commits;
    wr(11'h010, 8'h3c);
    wrsr(8'h0c);
    check("locked", commits - c, 0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence, reset driven off the sampling edge
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    commits = 0;
    ce = 1'b1;
    resetn = 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    t_write_read();
    t_protect();
    t_wp();
    t_abort_hold();
    t_wrdi();
    results();
  end
  // Watchdog well beyond the roughly 25 us of traffic
  initial
  begin
    #500us;
    n_fail++;
    results();
  end
endmodule
